// file: bench/asc_line_partner.sv
`timescale 1ns/1ns
`default_nettype none
module asc_line_partner
(
	// Clock
	input wire logic ref_clk,
	// Lines from the device
	input wire logic txd,
	input wire logic clk_o,
	input wire logic clk_oe,
	// Lines to the device
	output logic rxd,
	output logic clk_i
);
	int bit_cyc = 16;
	int rx_len = 10;
	int ph_bad = 0;
	int ph_ok = 0;
	int ph;
	logic busy = 1'b0;
	time t0 = 0;
	logic [11:0] sh;
	logic [11:0] got_q[$];
	// ----------------------------------------
	// Idle line and free running 16x clock
	// ----------------------------------------
	initial
	begin
		rxd = 1'b1;
		clk_i = 1'b0;
		forever @(posedge ref_clk) clk_i <= ~clk_i;
	end
	// ----------------------------------------
	// Frame sender
	// ----------------------------------------
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd <= bits[i];
			repeat (bit_cyc) @(posedge ref_clk);
		end
		rxd <= 1'b1;
	endtask
	// ----------------------------------------
	// Frame capture at bit centres
	// ----------------------------------------
	initial forever
	begin
		@(negedge txd);
		t0 = $time;
		busy = 1'b1;
		sh = '0;
		repeat (bit_cyc / 2) @(posedge ref_clk);
		for (int i = 0; i < rx_len; i++)
		begin
			sh[i] = txd;
			if (i < rx_len - 1)
				repeat (bit_cyc) @(posedge ref_clk);
		end
		busy = 1'b0;
		got_q.push_back(sh);
	end
	// Output clock phase inside a frame
	always @(posedge clk_o)
	begin
		ph = int'(($time - t0) / 20) % bit_cyc;
		if (busy && clk_oe && (ph < 6 || ph > 10))
			ph_bad++;
		else if (busy && clk_oe)
			ph_ok++;
	end
endmodule
`default_nettype wire

// file: bench/async_serial_channel_tb.sv
`timescale 1ns/1ns
`default_nettype none
module async_serial_channel_tb;
	import asc_pkg::*;
	logic ref_clk, rst, wr_en, rd_en, txd, rxd, ck_i, ck_o, ck_oe;
	logic rx_irq, tx_irq, tx_end_irq, rx_err_irq;
	logic [2:0] addr;
	logic [7:0] wr_data, rd_data, m, d0, d1, r, r1;
	logic [11:0] fr;
	logic [1:0] cks;
	logic [31:0] seed;
	int err_count, n_checks, n;
	asc_core dut_u
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(1'b1),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.txd(txd),
		.rxd(rxd),
		.serial_clk_pin_i(ck_i),
		.serial_clk_pin_o(ck_o),
		.serial_clk_pin_oe(ck_oe),
		.rx_irq(rx_irq),
		.tx_irq(tx_irq),
		.tx_end_irq(tx_end_irq),
		.rx_err_irq(rx_err_irq)
	);
	asc_line_partner pt
	(
		.ref_clk(ref_clk),
		.txd(txd),
		.clk_o(ck_o),
		.clk_oe(ck_oe),
		.rxd(rxd),
		.clk_i(ck_i)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] nxt();
		repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	function automatic logic [11:0] frame(input logic [7:0] md, input logic [7:0] d,
		input logic mp, output int nb);
		int nd;
		logic [11:0] f;
		nd = md[ASC_MODE_CHAR7] ? 7 : 8;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < nd; i++)
			f[i + 1] = d[i];
		nb = nd + 1;
		if (md[ASC_MODE_MP])
		begin
			f[nb] = mp;
			nb++;
		end
		else if (md[ASC_MODE_PAR_EN])
		begin
			f[nb] = (^d[6:0]) ^ (d[7] & (nd == 8)) ^ md[ASC_MODE_PAR_ODD];
			nb++;
		end
		nb += md[ASC_MODE_STOP2] ? 2 : 1;
		return f;
	endfunction
	task automatic report_and_stop();
		if (err_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data & k, e & k);
	endtask
	task automatic wait_till(input int w);
		for (int k = 0; k < 4000; k++)
		begin
			@(posedge ref_clk);
			if (w == 0 ? txd === 1'b0 : tx_end_irq === 1'b1)
				return;
		end
		err_count++;
		$display("unexpected at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	task automatic chk_frame(input logic [7:0] d, input logic mp);
		logic [11:0] e;
		logic [11:0] k;
		e = frame(m, d, mp, n);
		k = (12'h1 << n) - 12'h1;
		n_checks++;
		if (pt.got_q.size() == 0 || (pt.got_q.pop_front() & k) !== (e & k))
		begin
			err_count++;
			$display("unexpected at %0t: frame for %h", $time, d);
		end
	endtask
	task automatic rx_one(input logic [11:0] f, input logic [7:0] st, input logic [7:0] de);
		pt.send(f, n);
		rdc(ASC_OFS_STATUS, st, 8'hfc);
		rdc(ASC_OFS_RXDATA, de, 8'hff);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		addr = 3'h0;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		seed = 32'h57dbcc81;
		err_count = 0;
		n_checks = 0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(ASC_OFS_MODE, ASC_RST_MODE, 8'hff);
		rdc(ASC_OFS_CTRL, ASC_RST_CTRL, 8'hff);
		rdc(ASC_OFS_BAUD, ASC_RST_BAUD, 8'hff);
		rdc(ASC_OFS_STATUS, 8'h80, 8'hfc);
		rdc(3'h7, 8'h00, 8'hff);
		wr(ASC_OFS_BAUD, 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			d0 = nxt();
			d1 = nxt();
			r = nxt();
			m = {1'b0, i[3], i[2], r[0], i[0], i[1], 2'b00};
			cks = 2'(i % 3);
			pt.bit_cyc = (cks == ASC_CKS_EXT) ? 32 : 16;
			wr(ASC_OFS_CTRL, 8'h00);
			wr(ASC_OFS_MODE, m);
			wr(ASC_OFS_CTRL, {6'h3d, cks});
			fr = frame(m, d0, r[1], n);
			pt.rx_len = n;
			wr(ASC_OFS_TXDATA, d0);
			wr(ASC_OFS_STATUS, {7'h3f, r[1]});
			wait_till(0);
			repeat (2) @(posedge ref_clk);
			chk({7'h0, tx_irq}, 8'h01);
			wr(ASC_OFS_TXDATA, d1);
			wr(ASC_OFS_STATUS, {7'h3f, r[1]});
			wait_till(1);
			rdc(ASC_OFS_STATUS, 8'h84, 8'hfc);
			chk({7'h0, ck_oe}, {7'h0, cks == ASC_CKS_INT_OUT});
			chk_frame(d0, r[1]);
			chk_frame(d1, r[1]);
			fr = frame(m, r, r[2], n);
			rx_one(fr, 8'hc4, m[ASC_MODE_CHAR7] ? {1'b0, r[6:0]} : r);
			chk({7'h0, rx_irq}, 8'h01);
			wr(ASC_OFS_STATUS, 8'hbf);
		end
		chk(8'(pt.ph_bad), 8'h00);
		chk({7'h0, pt.ph_ok > 0}, 8'h01);
		m = 8'h20;
		pt.bit_cyc = 16;
		wr(ASC_OFS_CTRL, 8'h00);
		wr(ASC_OFS_MODE, m);
		wr(ASC_OFS_CTRL, 8'h74);
		r = nxt();
		fr = frame(m, r, 1'b0, n);
		rx_one(fr ^ 12'h200, 8'h8c, r);
		chk({6'h0, rx_irq, rx_err_irq}, 8'h01);
		rx_one(frame(m, ~r, 1'b0, n), 8'h8c, r);
		wr(ASC_OFS_CTRL, 8'h24);
		rdc(ASC_OFS_STATUS, 8'h8c, 8'hfc);
		rdc(ASC_OFS_RXDATA, r, 8'hff);
		chk({7'h0, rx_err_irq}, 8'h00);
		wr(ASC_OFS_CTRL, 8'h74);
		wr(ASC_OFS_STATUS, 8'hf7);
		rx_one(fr & 12'h3ff, 8'h94, r);
		wr(ASC_OFS_STATUS, 8'hef);
		r1 = nxt();
		rx_one(frame(m, r1, 1'b0, n), 8'hc4, r1);
		rx_one(frame(m, ~r1, 1'b0, n), 8'he4, r1);
		chk({6'h0, rx_irq, rx_err_irq}, 8'h03);
		wr(ASC_OFS_STATUS, 8'h87);
		r = nxt();
		rx_one(frame(m, r, 1'b0, n), 8'hc4, r);
		wr(ASC_OFS_TXDATA, r);
		wr(ASC_OFS_STATUS, 8'h7f);
		wait_till(0);
		wr(ASC_OFS_STATUS, 8'h7f);
		rdc(ASC_OFS_STATUS, 8'h40, 8'hc0);
		wr(ASC_OFS_CTRL, 8'h14);
		rdc(ASC_OFS_STATUS, 8'h80, 8'h80);
		chk({7'h0, txd}, 8'h01);
		report_and_stop();
	end
endmodule
`default_nettype wire

// file: core/asc_core.sv
`timescale 1ns/1ns
`default_nettype none
module asc_core
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Serial line
	output logic txd,
	input wire logic rxd,
	// Serial clock pin
	input wire logic serial_clk_pin_i,
	output logic serial_clk_pin_o,
	output logic serial_clk_pin_oe,
	// Interrupt requests
	output logic rx_irq,
	output logic tx_irq,
	output logic tx_end_irq,
	output logic rx_err_irq
);
	import asc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] mode_reg;
		logic [7:0] control_reg;
		logic [7:0] baud;
		logic [7:0] tx_holding_reg;
		logic [7:0] rx_holding_reg;
		logic tx_empty_flag;
		logic rx_full_flag;
		logic overrun_flag;
		logic framing_flag;
		logic parity_flag;
		logic tx_done_flag;
		logic mpb_rx;
		logic mpb_tx;
		logic [7:0] div;
		logic sclk_prev;
		asc_tx_e tx_st;
		logic [3:0] tx_ph;
		logic [2:0] tx_bit;
		logic [7:0] tx_shifter;
		logic tx_extra;
		logic txd;
		asc_rx_e rx_st;
		logic [3:0] rx_ph;
		logic [2:0] rx_bit;
		logic [7:0] rx_shifter;
		logic rx_extra;
		logic [7:0] rd_data;
		logic rx_irq;
		logic tx_irq;
		logic tx_end_irq;
		logic rx_err_irq;
		logic clk_oe;
	} asc_state_s;

	asc_state_s q;
	asc_state_s d;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic data_parity(input logic [7:0] v, input logic seven);
		data_parity = ^(seven ? {1'b0, v[6:0]} : v);
	endfunction

	function automatic asc_state_s tx_load(input asc_state_s s);
		asc_state_s r;
		r = s;
		r.tx_shifter = s.tx_holding_reg;
		r.tx_extra = s.mode_reg[ASC_MODE_MP] ? s.mpb_tx :
			(data_parity(s.tx_holding_reg, s.mode_reg[ASC_MODE_CHAR7]) ^
			s.mode_reg[ASC_MODE_PAR_ODD]);
		r.tx_empty_flag = 1'b1;
		r.tx_done_flag = 1'b0;
		r.tx_st = ASC_TX_START;
		r.tx_ph = 4'h0;
		r.tx_bit = 3'h0;
		r.txd = 1'b0;
		tx_load = r;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic tick;
		logic [1:0] cks;
		logic extra_on;
		logic [2:0] last_bit;
		logic [7:0] rx_word;
		logic perr;
		logic any_err;
		tick = 1'b0;
		cks = 2'h0;
		extra_on = 1'b0;
		last_bit = 3'h0;
		rx_word = 8'h00;
		perr = 1'b0;
		any_err = 1'b0;
		d = q;

		// Register writes
		if (wr_en)
		begin
			case (addr)
				ASC_OFS_MODE: d.mode_reg = wr_data;
				ASC_OFS_CTRL: d.control_reg = wr_data;
				ASC_OFS_BAUD: d.baud = wr_data;
				ASC_OFS_TXDATA: d.tx_holding_reg = wr_data;
				ASC_OFS_STATUS:
				begin
					d.tx_empty_flag = q.tx_empty_flag & wr_data[ASC_ST_TX_EMPTY_FLAG];
					d.rx_full_flag = q.rx_full_flag & wr_data[ASC_ST_RX_FULL_FLAG];
					d.overrun_flag = q.overrun_flag & wr_data[ASC_ST_OER];
					d.framing_flag = q.framing_flag & wr_data[ASC_ST_FER];
					d.parity_flag = q.parity_flag & wr_data[ASC_ST_PER];
					d.tx_done_flag = q.tx_done_flag & wr_data[ASC_ST_TX_DONE_FLAG];
					d.mpb_tx = wr_data[ASC_ST_MPBT];
				end
				default: d.mode_reg = d.mode_reg;
			endcase
		end

		// Register reads, data one cycle later
		d.rd_data = 8'h00;
		if (rd_en)
		begin
			case (addr)
				ASC_OFS_MODE: d.rd_data = q.mode_reg;
				ASC_OFS_CTRL: d.rd_data = q.control_reg;
				ASC_OFS_BAUD: d.rd_data = q.baud;
				ASC_OFS_TXDATA: d.rd_data = q.tx_holding_reg;
				ASC_OFS_STATUS: d.rd_data = {q.tx_empty_flag, q.rx_full_flag, q.overrun_flag,
					q.framing_flag, q.parity_flag, q.tx_done_flag, q.mpb_rx, q.mpb_tx};
				ASC_OFS_RXDATA: d.rd_data = q.rx_holding_reg;
				default: d.rd_data = 8'h00;
			endcase
		end

		// Oversampling tick from the selected source
		cks = {q.control_reg[ASC_CTRL_CKS_HI], q.control_reg[ASC_CTRL_CKS_LO]};
		d.sclk_prev = serial_clk_pin_i;
		if (q.div == 8'h00)
			d.div = q.baud;
		else
			d.div = q.div - 8'h01;
		if (!q.mode_reg[ASC_MODE_SYNC])
		begin
			case (cks)
				ASC_CKS_INT: tick = (q.div == 8'h00);
				ASC_CKS_INT_OUT: tick = (q.div == 8'h00);
				ASC_CKS_EXT: tick = serial_clk_pin_i & ~q.sclk_prev;
				default: tick = 1'b0;
			endcase
		end

		extra_on = q.mode_reg[ASC_MODE_MP] | q.mode_reg[ASC_MODE_PAR_EN];
		last_bit = q.mode_reg[ASC_MODE_CHAR7] ? ASC_LAST_BIT7 : ASC_LAST_BIT8;

		// Transmitter
		if (tick)
			d.tx_ph = q.tx_ph + 4'h1;
		if (!q.control_reg[ASC_CTRL_TE])
		begin
			d.tx_st = ASC_TX_IDLE;
			d.txd = 1'b1;
		end
		else
		begin
			case (q.tx_st)
				ASC_TX_IDLE:
				begin
					d.txd = 1'b1;
					if (!q.tx_empty_flag)
						d = tx_load(d);
				end
				ASC_TX_START:
					if (tick && q.tx_ph == ASC_TICK_LAST)
					begin
						d.tx_st = ASC_TX_DATA;
						d.txd = q.tx_shifter[0];
					end
				ASC_TX_DATA:
					if (tick && q.tx_ph == ASC_TICK_LAST)
					begin
						d.tx_shifter = {1'b0, q.tx_shifter[7:1]};
						d.tx_bit = q.tx_bit + 3'h1;
						d.txd = q.tx_shifter[1];
						if (q.tx_bit == last_bit)
						begin
							d.tx_st = extra_on ? ASC_TX_EXTRA : ASC_TX_STOP;
							d.txd = extra_on ? q.tx_extra : 1'b1;
						end
					end
				ASC_TX_EXTRA:
					if (tick && q.tx_ph == ASC_TICK_LAST)
					begin
						d.tx_st = ASC_TX_STOP;
						d.txd = 1'b1;
					end
				ASC_TX_STOP, ASC_TX_STOP2:
					if (tick && q.tx_ph == ASC_TICK_LAST)
					begin
						if (q.tx_st == ASC_TX_STOP && q.mode_reg[ASC_MODE_STOP2])
							d.tx_st = ASC_TX_STOP2;
						else if (!q.tx_empty_flag)
							d = tx_load(d);
						else
						begin
							d.tx_done_flag = 1'b1;
							d.tx_st = ASC_TX_IDLE;
							d.txd = 1'b1;
						end
					end
				default:
				begin
					d.tx_st = ASC_TX_IDLE;
					d.txd = 1'b1;
				end
			endcase
		end
		if (!d.control_reg[ASC_CTRL_TE])
			d.tx_empty_flag = 1'b1;

		// Receiver
		any_err = q.overrun_flag | q.framing_flag | q.parity_flag;
		if (tick)
			d.rx_ph = q.rx_ph + 4'h1;
		if (!q.control_reg[ASC_CTRL_RE])
			d.rx_st = ASC_RX_IDLE;
		else
		begin
			case (q.rx_st)
				ASC_RX_IDLE:
					if (!any_err && !rxd)
					begin
						d.rx_st = ASC_RX_START;
						d.rx_ph = 4'h0;
					end
				ASC_RX_START:
					if (tick && q.rx_ph == ASC_TICK_CENTER)
					begin
						d.rx_st = rxd ? ASC_RX_IDLE : ASC_RX_DATA;
						d.rx_ph = 4'h0;
						d.rx_bit = 3'h0;
					end
				ASC_RX_DATA:
					if (tick && q.rx_ph == ASC_TICK_LAST)
					begin
						d.rx_shifter = {rxd, q.rx_shifter[7:1]};
						d.rx_bit = q.rx_bit + 3'h1;
						if (q.rx_bit == last_bit)
							d.rx_st = extra_on ? ASC_RX_EXTRA : ASC_RX_STOP;
					end
				ASC_RX_EXTRA:
					if (tick && q.rx_ph == ASC_TICK_LAST)
					begin
						d.rx_extra = rxd;
						d.rx_st = ASC_RX_STOP;
					end
				ASC_RX_STOP:
					if (tick && q.rx_ph == ASC_TICK_LAST)
					begin
						d.rx_st = ASC_RX_IDLE;
						rx_word = q.mode_reg[ASC_MODE_CHAR7] ? {1'b0, q.rx_shifter[7:1]} :
							q.rx_shifter;
						perr = q.mode_reg[ASC_MODE_PAR_EN] & ~q.mode_reg[ASC_MODE_MP] &
							(data_parity(rx_word, 1'b0) ^ q.rx_extra ^
							q.mode_reg[ASC_MODE_PAR_ODD]);
						if (q.rx_full_flag)
							d.overrun_flag = 1'b1;
						else
						begin
							d.rx_holding_reg = rx_word;
							if (q.mode_reg[ASC_MODE_MP])
								d.mpb_rx = q.rx_extra;
							if (perr)
								d.parity_flag = 1'b1;
							if (!rxd)
								d.framing_flag = 1'b1;
							if (!perr && rxd)
								d.rx_full_flag = 1'b1;
						end
					end
				default: d.rx_st = ASC_RX_IDLE;
			endcase
		end

		// Interrupt levels
		d.rx_irq = d.rx_full_flag & d.control_reg[ASC_CTRL_RIE];
		d.rx_err_irq = (d.overrun_flag | d.framing_flag | d.parity_flag) &
			d.control_reg[ASC_CTRL_RIE];
		d.tx_irq = d.tx_empty_flag & d.control_reg[ASC_CTRL_TIE];
		d.tx_end_irq = d.tx_done_flag & d.control_reg[ASC_CTRL_TX_DONE_IRQ_ENABLE];
		d.clk_oe = ~d.mode_reg[ASC_MODE_SYNC] & ({d.control_reg[ASC_CTRL_CKS_HI],
			d.control_reg[ASC_CTRL_CKS_LO]} == ASC_CKS_INT_OUT);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.mode_reg <= ASC_RST_MODE;
			q.control_reg <= ASC_RST_CTRL;
			q.baud <= ASC_RST_BAUD;
			q.tx_empty_flag <= 1'b1;
			q.sclk_prev <= 1'b1;
			q.tx_st <= ASC_TX_IDLE;
			q.rx_st <= ASC_RX_IDLE;
			q.txd <= 1'b1;
		end
		else if (ce)
			q <= d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rd_data = q.rd_data;
	assign txd = q.txd;
	assign serial_clk_pin_o = q.tx_ph[3];
	assign serial_clk_pin_oe = q.clk_oe;
	assign rx_irq = q.rx_irq;
	assign tx_irq = q.tx_irq;
	assign tx_end_irq = q.tx_end_irq;
	assign rx_err_irq = q.rx_err_irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic tick_w;
	assign tick_w = ~q.mode_reg[ASC_MODE_SYNC] & (((q.control_reg[1:0] == ASC_CKS_INT) |
		(q.control_reg[1:0] == ASC_CKS_INT_OUT)) ? (q.div == 8'h00) :
		(q.control_reg[1:0] == ASC_CKS_EXT) ? (serial_clk_pin_i & ~q.sclk_prev) : 1'b0);

	AST_TX_IDLE_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
		(q.tx_st == ASC_TX_IDLE) |-> q.txd)
		else $error("tx line not high while idle");
	AST_TX_START_LOW: assert property (@(posedge ref_clk) disable iff (rst)
		(q.tx_st == ASC_TX_START) |-> !q.txd)
		else $error("start bit not low");
	AST_TE_FORCES_EMPTY: assert property (@(posedge ref_clk) disable iff (rst)
		!q.control_reg[ASC_CTRL_TE] |-> q.tx_empty_flag)
		else $error("empty flag low while transmit disabled");
	AST_LOAD_SETS_EMPTY: assert property (@(posedge ref_clk) disable iff (rst)
		(q.tx_st == ASC_TX_IDLE) ##1 (q.tx_st == ASC_TX_START) |-> q.tx_empty_flag)
		else $error("load did not set empty flag");
	AST_START_REJECT: assert property (@(posedge ref_clk) disable iff (rst)
		ce && q.rx_st == ASC_RX_START && tick_w && q.rx_ph == ASC_TICK_CENTER && rxd
		&& q.control_reg[ASC_CTRL_RE] |=> q.rx_st == ASC_RX_IDLE)
		else $error("false start not rejected at centre");
	AST_OVERRUN_KEEPS: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(q.overrun_flag) |-> $stable(q.rx_holding_reg) && q.rx_full_flag)
		else $error("overrun moved data");
	AST_ERR_HALTS: assert property (@(posedge ref_clk) disable iff (rst)
		(q.overrun_flag || q.framing_flag || q.parity_flag) && q.rx_st == ASC_RX_IDLE
		|=> q.rx_st == ASC_RX_IDLE)
		else $error("reception resumed with error set");
	AST_DONE_CAUSE: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(q.tx_done_flag) |-> $past(q.tx_empty_flag) && q.tx_st == ASC_TX_IDLE
		&& ($past(q.tx_st) == ASC_TX_STOP || $past(q.tx_st) == ASC_TX_STOP2))
		else $error("done flag set outside stop end");
	AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
		rx_irq == (q.rx_full_flag & q.control_reg[ASC_CTRL_RIE])
		&& tx_end_irq == (q.tx_done_flag & q.control_reg[ASC_CTRL_TX_DONE_IRQ_ENABLE]))
		else $error("irq level mismatch");
endmodule
`default_nettype wire

// file: core/asc_pkg.sv
package asc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] ASC_OFS_MODE = 3'h0;
	localparam logic [2:0] ASC_OFS_CTRL = 3'h1;
	localparam logic [2:0] ASC_OFS_BAUD = 3'h2;
	localparam logic [2:0] ASC_OFS_TXDATA = 3'h3;
	localparam logic [2:0] ASC_OFS_STATUS = 3'h4;
	localparam logic [2:0] ASC_OFS_RXDATA = 3'h5;
	// ----------------------------------------
	// Mode register fields
	// ----------------------------------------
	localparam int ASC_MODE_SYNC = 7;
	localparam int ASC_MODE_CHAR7 = 6;
	localparam int ASC_MODE_PAR_EN = 5;
	localparam int ASC_MODE_PAR_ODD = 4;
	localparam int ASC_MODE_STOP2 = 3;
	localparam int ASC_MODE_MP = 2;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int ASC_CTRL_TIE = 7;
	localparam int ASC_CTRL_RIE = 6;
	localparam int ASC_CTRL_TE = 5;
	localparam int ASC_CTRL_RE = 4;
	localparam int ASC_CTRL_TX_DONE_IRQ_ENABLE = 2;
	localparam int ASC_CTRL_CKS_HI = 1;
	localparam int ASC_CTRL_CKS_LO = 0;
	localparam logic [1:0] ASC_CKS_INT = 2'h0;
	localparam logic [1:0] ASC_CKS_INT_OUT = 2'h1;
	localparam logic [1:0] ASC_CKS_EXT = 2'h2;
	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int ASC_ST_TX_EMPTY_FLAG = 7;
	localparam int ASC_ST_RX_FULL_FLAG = 6;
	localparam int ASC_ST_OER = 5;
	localparam int ASC_ST_FER = 4;
	localparam int ASC_ST_PER = 3;
	localparam int ASC_ST_TX_DONE_FLAG = 2;
	localparam int ASC_ST_MPBR = 1;
	localparam int ASC_ST_MPBT = 0;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] ASC_RST_MODE = 8'h00;
	localparam logic [7:0] ASC_RST_CTRL = 8'h00;
	localparam logic [7:0] ASC_RST_BAUD = 8'h1a;
	localparam logic [3:0] ASC_TICK_CENTER = 4'h7;
	localparam logic [3:0] ASC_TICK_LAST = 4'hf;
	localparam logic [2:0] ASC_LAST_BIT8 = 3'h7;
	localparam logic [2:0] ASC_LAST_BIT7 = 3'h6;
	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		ASC_TX_IDLE = 3'h0,
		ASC_TX_START = 3'h1,
		ASC_TX_DATA = 3'h3,
		ASC_TX_EXTRA = 3'h2,
		ASC_TX_STOP = 3'h6,
		ASC_TX_STOP2 = 3'h7
	} asc_tx_e;
	typedef enum logic [2:0] {
		ASC_RX_IDLE = 3'h0,
		ASC_RX_START = 3'h1,
		ASC_RX_DATA = 3'h3,
		ASC_RX_EXTRA = 3'h2,
		ASC_RX_STOP = 3'h6
	} asc_rx_e;
endpackage
